// *** src/bank_mem_defines.vh ***
// address layout, bank pointer and access window constants for the banked data memory
`ifndef BANK_MEM_DEFINES_VH
`define BANK_MEM_DEFINES_VH
`define ADDR_W          12
`define BANK_W          4
`define OFFS_W          8
`define DATA_W          8
`define NUM_BANKS       16
`define BANK_BYTES      256
`define BANKS_SMALL     8
`define BANK_PTR_ADDR   12'hfe0
`define BANK_PTR_RESET  4'h0
`define ACC_SPLIT       8'h60
`define SFR_BANK        4'hf
`define ACC_ROUTE_ABS   4'h1
`define ACC_ROUTE_ACC   4'h2
`define ACC_ROUTE_BANK  4'h4
`define ACC_ROUTE_FULL  4'h8
`endif

// *** src/addr_former.v ***
// data address former: full, bank pointer or access window resolution
`timescale 1ns/1ns
`include "bank_mem_defines.vh"
module addr_former #(
  parameter ACC_SPLIT = 8'h60,
  parameter SFR_BANK  = 4'hf
) (
  input  wire [3:0]  route_i,
  input  wire [11:0] full_addr_i,
  input  wire [7:0]  offset_i,
  input  wire [3:0]  bank_i,
  output reg  [11:0] addr_o
);
  // pick the address source for the current access
  always @* begin
    case (route_i)
      // [RULE10] full address move
      `ACC_ROUTE_FULL: addr_o = full_addr_i;
      `ACC_ROUTE_ABS:  addr_o = full_addr_i;
      // [RULE14] access window split
      `ACC_ROUTE_ACC: begin
        if (offset_i < ACC_SPLIT)
          addr_o = {4'h0, offset_i};
        else
          addr_o = {SFR_BANK, offset_i};
      end
      // [RULE6] bank pointer concatenation
      `ACC_ROUTE_BANK: addr_o = {bank_i, offset_i};
      default:         addr_o = {bank_i, offset_i};
    endcase
  end
endmodule

// *** src/banked_data_memory.v ***
// banked data memory with bank pointer, access window and full address paths
//
// Overview of operation
// [RULE1] every data byte has a 12-bit address, for up to 4,096 bytes.
// [RULE2] the space is split into up to 16 banks of 256 bytes, bank number on top.
// [RULE3] full variant implements 16 banks (4 Kbytes), small variant only the first 8 (2 Kbytes).
// [RULE4] reads of unimplemented locations return all zeros.
// [RULE5] a 256-byte access window reaches low bank 0 and chosen registers without the pointer.
// [RULE6] an address is either a full 12-bit operand or a 4-bit bank pointer above an 8-bit offset.
// [RULE7] the bank pointer keeps only its low four bits; the upper four read zero, ignore writes.
// [RULE8] a load-bank instruction loads the bank pointer with a literal.
// [RULE9] writes to unimplemented banks are dropped, reads give zero, status still updates.
// [RULE10] the full-address move takes 12-bit source and destination and ignores the pointer.
// [RULE11] all other instructions resolve the 8-bit operand by the pointer or the window; full_mode_i reads and writes use full_addr_i instead.
// [RULE12] every location is reachable by direct, indirect and indexed addressing, across banks.
// [RULE13] an access-select bit picks window or pointer resolution of the offset.
// [RULE14] the window maps low offsets to bank 0 bottom and high offsets to the register bank top.
`timescale 1ns/1ns
`include "bank_mem_defines.vh"
module banked_data_memory #(
  parameter NUM_BANKS = 16
) (
  input  wire        clock_i,
  input  wire        nrst_i,
  input  wire        rd_en_i,
  input  wire        wr_en_i,
  input  wire        access_sel_i,
  input  wire        full_mode_i,
  input  wire [7:0]  offset_i,
  input  wire [11:0] full_addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        move_en_i,
  input  wire [11:0] move_src_i,
  input  wire [11:0] move_dst_i,
  input  wire        load_bank_en_i,
  input  wire [7:0]  load_bank_lit_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_valid_o,
  output wire [7:0]  bank_pointer_o,
  output wire        access_ok_o
);
  // [RULE1] 12-bit addressed byte space
  reg  [7:0]  mem [0:4095];
  reg  [3:0]  bank_pointer_register_r;
  reg  [3:0]  route;
  wire [11:0] addr;
  wire [7:0]  rd_byte;
  wire [7:0]  move_byte;

  // implemented-location check, shared by every path
  // [RULE2] bank number on top bits
  // [RULE3] banks at and above NUM_BANKS absent
  function impl_f;
    input [11:0] a;
    begin
      impl_f = (a[11:8] < NUM_BANKS);
    end
  endfunction

  // [RULE13] access select route
  always @* begin
    if (full_mode_i)
      route = `ACC_ROUTE_ABS;
    else if (access_sel_i)
      route = `ACC_ROUTE_ACC;
    else
      route = `ACC_ROUTE_BANK;
  end

  // [RULE11] offset resolution
  // [RULE5] window bypasses the pointer
  addr_former #(
    .ACC_SPLIT (`ACC_SPLIT),
    .SFR_BANK  (`SFR_BANK)
  ) u_addr (
    .route_i     (route),
    .full_addr_i (full_addr_i),
    .offset_i    (offset_i),
    .bank_i      (bank_pointer_register_r),
    .addr_o      (addr)
  );

  // [RULE7] upper pointer bits read zero
  assign bank_pointer_o = {4'h0, bank_pointer_register_r};
  // [RULE9] status behaves as successful
  assign access_ok_o = rd_en_i | wr_en_i | move_en_i;

  // [RULE4] zero for unimplemented reads
  assign rd_byte = (addr == `BANK_PTR_ADDR) ? bank_pointer_o :
                   (impl_f(addr) ? mem[addr] : 8'h00);
  assign move_byte = (move_src_i == `BANK_PTR_ADDR) ? bank_pointer_o :
                     (impl_f(move_src_i) ? mem[move_src_i] : 8'h00);

  // [RULE8] bank pointer load and writes
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bank_pointer_register_r <= `BANK_PTR_RESET;
    end else if (load_bank_en_i) begin
      bank_pointer_register_r <= load_bank_lit_i[3:0];
    end else if (move_en_i && move_dst_i == `BANK_PTR_ADDR) begin
      bank_pointer_register_r <= move_byte[3:0];
    end else if (wr_en_i && addr == `BANK_PTR_ADDR) begin
      bank_pointer_register_r <= wr_data_i[3:0];
    end
  end

  // [RULE9] drop writes to missing banks
  always @(posedge clock_i) begin
    if (move_en_i) begin
      if (impl_f(move_dst_i) && move_dst_i != `BANK_PTR_ADDR)
        mem[move_dst_i] <= move_byte;
    end else if (wr_en_i && impl_f(addr) && addr != `BANK_PTR_ADDR) begin
      mem[addr] <= wr_data_i;
    end
  end

  // [RULE12] registered read data
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i)
        rd_data_o <= rd_byte;
    end
  end
endmodule

// *** verification/bdm_props.sv ***
// port assertions for the banked data memory
`timescale 1ns/1ns
module bdm_props #(parameter NUM_BANKS = 16) (
  input wire        clock_i, nrst_i, rd_en_i, wr_en_i, move_en_i, load_bank_en_i, full_mode_i,
  input wire        rd_valid_o, access_ok_o,
  input wire [11:0] full_addr_i,
  input wire [7:0]  load_bank_lit_i, rd_data_o, bank_pointer_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_ans;
    ##1 rd_valid_o;
  endsequence
  AST_RD_VALID: assert property (rd_en_i |-> s_ans) else $error("no valid");
  AST_NO_VALID: assert property (!rd_en_i |=> !rd_valid_o) else $error("stray valid");
  AST_RD_HOLD: assert property (!rd_en_i |=> $stable(rd_data_o)) else $error("data moved");
  AST_PTR_HIGH: assert property (bank_pointer_o[7:4] == 4'h0) else $error("ptr high");
  AST_PTR_LOAD: assert property (load_bank_en_i |=>
    bank_pointer_o == ($past(load_bank_lit_i) & 8'h0f)) else $error("ptr load");
  AST_PTR_KEEP: assert property (!(load_bank_en_i || wr_en_i || move_en_i) |=>
    $stable(bank_pointer_o)) else $error("ptr moved");
  AST_STATUS: assert property (rd_en_i || wr_en_i |-> access_ok_o) else $error("no ok");
  AST_UNIMPL: assert property (rd_en_i && full_mode_i && full_addr_i[11:8] >= NUM_BANKS
    && full_addr_i[11:8] < 4'hf |=> rd_data_o == 8'h00) else $error("not zero");
endmodule
bind banked_data_memory bdm_props #(.NUM_BANKS(NUM_BANKS)) props_u (.*);

// *** verification/core_model.sv ***
// core side model issuing data memory requests
`timescale 1ns/1ns
module core_model (
  input  wire         clock_i,
  output logic        rd_en_i, wr_en_i, move_en_i, load_bank_en_i, access_sel_i, full_mode_i,
  output logic [7:0]  offset_i, wr_data_i, load_bank_lit_i,
  output logic [11:0] full_addr_i, move_src_i, move_dst_i
);
  // drive every request line at once
  task put(input [5:0] en, input [11:0] a, input [11:0] b, input [7:0] d);
    {rd_en_i, wr_en_i, move_en_i, load_bank_en_i, access_sel_i, full_mode_i} = en;
    {full_addr_i, move_src_i, move_dst_i, offset_i} = {a, a, b, a[7:0]};
    {wr_data_i, load_bank_lit_i} = {d, d};
  endtask
  initial put('0, '0, '0, '0);
  // hold for one edge, then release with inverted lines
  task req(input [5:0] en, input [11:0] a, input [11:0] b, input [7:0] d);
    @(posedge clock_i) #1 put(en, a, b, d);
    @(posedge clock_i) #1 put(en & 6'h03, ~a, ~b, ~d);
  endtask
endmodule

// *** verification/banked_data_memory_bench.sv ***
// bench for the banked data memory, small variant
`timescale 1ns/1ns
module banked_data_memory_bench;
  logic        clock_i, nrst_i, rd_en_i, wr_en_i, move_en_i, load_bank_en_i, access_sel_i;
  logic        full_mode_i, rd_valid_o, access_ok_o;
  logic [7:0]  offset_i, wr_data_i, load_bank_lit_i, rd_data_o, bank_pointer_o;
  logic [11:0] full_addr_i, move_src_i, move_dst_i;
  int          fail_count = 0, total_checks = 0;
  banked_data_memory #(.NUM_BANKS(8)) dut_u (.*);
  core_model core_u (.*);
  // compare and count
  task chk(input [8:0] got, input [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %h %h", $time, got, exp);
    end
  endtask
  // one request; a read checks valid and data
  task op(input [5:0] en, input [11:0] a, input [11:0] b, input [7:0] d);
    core_u.req(en, a, b, d);
    if (en[5]) chk({rd_valid_o, rd_data_o}, {1'b1, d});
  endtask
  task wrap_up;
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // 25 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  // reset then the access sequence
  initial begin
    nrst_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    chk({1'b0, bank_pointer_o}, '0);
    op(6'h04, '0, '0, 8'ha5);
    chk({1'b0, bank_pointer_o}, 9'h005);
    op(6'h11, 12'h523, '0, 8'h5a);
    op(6'h20, 12'h023, '0, 8'h5a);
    op(6'h11, 12'h020, '0, 8'h3c);
    op(6'h22, 12'h020, '0, 8'h3c);
    op(6'h22, 12'h0e0, '0, 8'h05);
    op(6'h08, 12'h523, 12'h7ff, '0);
    op(6'h21, 12'h7ff, '0, 8'h5a);
    op(6'h11, 12'h9aa, '0, 8'hff);
    op(6'h21, 12'h9aa, '0, 8'h00);
    wrap_up();
  end
endmodule
